//--- hw/bcoc_defines.svh
// Constants for the bus clock output control block
`ifndef BCOC_DEFINES_SVH
`define BCOC_DEFINES_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BCOC_ADDR_SLOWDIV  8'he0
`define BCOC_ADDR_CTRL     8'he1
`define BCOC_ADDR_STATUS   8'he2
// ----------------------------------------
// Control fields, divider reset value and clock periods
// ----------------------------------------
`define BCOC_CTRL_EN_BIT      0
`define BCOC_CTRL_STOP_BIT    1
`define BCOC_CTRL_STR_BIT     2
`define BCOC_CTRL_STRN_LSB    4
`define BCOC_STRN_W           2
`define BCOC_SLOWDIV_RST      8'h00
`define BCOC_OSC_PERIOD_NS    100
`define BCOC_SYS_PERIOD_NS    100
`define BCOC_OSC_CYC          ((`BCOC_OSC_PERIOD_NS + `BCOC_SYS_PERIOD_NS - 1) / `BCOC_SYS_PERIOD_NS)
`endif

//--- hw/bcoc_pkg.sv
// Types shared by the bus clock output control modules
package bcoc_pkg;
   typedef enum logic [1:0] {
      BCOC_NORM_SINGLE = 2'h0,
      BCOC_SPEC_SINGLE = 2'h1,
      BCOC_SPEC_PERIPH = 2'h2,
      BCOC_EXPANDED    = 2'h3
   } bcoc_mode_t;
   typedef enum logic [1:0] {
      BCOC_PH_LOW  = 2'h0,
      BCOC_PH_HIGH = 2'h1,
      BCOC_PH_HOLD = 2'h3
   } bcoc_phase_t;
endpackage

//--- hw/bcoc_div_if.sv
// Interface between the top and the phase divider
`timescale 1ns/10ps
interface bcoc_div_if;
   logic       step;
   logic [7:0] div;
   logic       stop;
   logic       stretch;
   logic [1:0] nstretch;
   logic       half_tick;
   logic       clk_level;
   modport ctrl (output step, div, stop, stretch, nstretch, input half_tick, clk_level);
   modport gen  (input step, div, stop, stretch, nstretch, output half_tick, clk_level);
endinterface

//--- hw/bcoc_phase_div.sv
// Phase generator producing the bus clock level from oscillator ticks
`timescale 1ns/10ps
module bcoc_phase_div (
   input  wire logic clk_in,
   input  wire logic rst_in,
   bcoc_div_if.gen   dv
);
   logic [7:0]              cnt_q;
   logic [1:0]              str_q;
   bcoc_pkg::bcoc_phase_t   ph_q;
   logic                    tick;

   // ----------------------------------------
   // Slow divider: a half period lasts div+1 oscillator steps
   // ----------------------------------------
   // Compare with >= so that lowering the divider mid count cannot stall for a full wrap
   assign tick = dv.step && !dv.stop && (cnt_q >= dv.div);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_q <= 8'h00;
      end else if (dv.step && !dv.stop) begin
         cnt_q <= (cnt_q >= dv.div) ? 8'h00 : 8'(cnt_q + 8'h01);
      end
   end

   // Low, high, then extra high periods while stretching; stop freezes all
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ph_q  <= bcoc_pkg::BCOC_PH_LOW;
         str_q <= 2'h0;
      end else if (tick) begin
         unique case (ph_q)
            bcoc_pkg::BCOC_PH_LOW: begin
               ph_q  <= bcoc_pkg::BCOC_PH_HIGH;
               str_q <= dv.stretch ? dv.nstretch : 2'h0;
            end
            bcoc_pkg::BCOC_PH_HIGH: begin
               ph_q <= (str_q != 2'h0) ? bcoc_pkg::BCOC_PH_HOLD : bcoc_pkg::BCOC_PH_LOW;
            end
            bcoc_pkg::BCOC_PH_HOLD: begin
               if (str_q == 2'h1) begin
                  ph_q <= bcoc_pkg::BCOC_PH_LOW;
               end
               str_q <= 2'(str_q - 2'h1);
            end
            default: ph_q <= bcoc_pkg::BCOC_PH_LOW;
         endcase
      end
   end

   assign dv.half_tick = tick;
   assign dv.clk_level = (ph_q != bcoc_pkg::BCOC_PH_LOW);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Without a pending stretch every half tick flips the level
   a_halved: assert property (@(posedge clk_in) disable iff (rst_in)
      (dv.div == 8'h00 && tick && (ph_q == bcoc_pkg::BCOC_PH_LOW || str_q == 2'h0))
      |=> $changed(dv.clk_level))
      else $error("clock not halved");
   // A pending stretch keeps the level high past the normal high half
   a_stretch: assert property (@(posedge clk_in) disable iff (rst_in)
      (tick && ph_q == bcoc_pkg::BCOC_PH_HIGH && str_q != 2'h0) |=> dv.clk_level)
      else $error("stretch lost");
endmodule // bcoc_phase_div

//--- hw/bcoc_top.sv
// Bus clock output control: generation, gating, stop and slow divider
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "bcoc_defines.svh"

module bcoc_top #(
   parameter bit HAS_SLOWDIV = 1'b1
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [1:0] mode_in,
   input  wire logic       osc_tick_in,
   input  wire logic       bus_clock_pin_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out,
   output logic            bus_clock_pin_out,
   output logic            bus_clock_pin_oe_out,
   output logic            bus_clock_out,
   output logic            addr_phase_out
);
   bcoc_div_if dv ();
   bcoc_pkg::bcoc_mode_t mode_q;
   logic       osc_s1_q, osc_s2_q, osc_s3_q;
   logic [1:0] mode_s1_q, mode_s2_q;
   logic       pin_s1_q, pin_s2_q;
   logic       strt_q;
   logic [7:0] slowdiv_q;
   logic       en_q, stop_q, str_q;
   logic [1:0] nstr_q;
   logic       en_act_q;
   logic       clk_int;

   // ----------------------------------------
   // Strap capture and input synchronisers
   // ----------------------------------------
   // Mode straps are sampled in the first cycle after reset is lifted
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         strt_q <= 1'b1;
         mode_q <= bcoc_pkg::BCOC_NORM_SINGLE;
      end else if (strt_q) begin
         strt_q <= 1'b0;
         mode_q <= bcoc_pkg::bcoc_mode_t'(mode_s2_q);
      end
   end

   // Oscillator, pin and straps are asynchronous; only the second stage feeds logic, plus the third for the oscillator edge.
   // No reset here, so a high oscillator level at release cannot fake an edge
   always_ff @(posedge clk_in) begin
      osc_s1_q  <= osc_tick_in;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      pin_s1_q  <= bus_clock_pin_in;
      pin_s2_q  <= pin_s1_q;
      mode_s1_q <= mode_in;
      mode_s2_q <= mode_s1_q;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Only rising oscillator edges step, so at div 0 the bus runs at half that rate
   assign dv.step     = osc_s2_q && !osc_s3_q;
   assign dv.div      = HAS_SLOWDIV ? slowdiv_q : 8'h00;
   assign dv.stop     = stop_q;
   assign dv.stretch  = str_q;
   assign dv.nstretch = nstr_q;

   // Divider only exists on parts with it; else writes are dropped
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         slowdiv_q <= `BCOC_SLOWDIV_RST;
      end else if (wr_in && addr_in == `BCOC_ADDR_SLOWDIV && HAS_SLOWDIV) begin
         slowdiv_q <= wdata_in;
      end
   end

   // Enable default follows the strapped mode, at the strap cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         en_q   <= 1'b0;
         stop_q <= 1'b0;
         str_q  <= 1'b0;
         nstr_q <= 2'h0;
      end else if (strt_q) begin
         en_q <= (bcoc_pkg::bcoc_mode_t'(mode_s2_q) == bcoc_pkg::BCOC_SPEC_SINGLE);
      end else if (wr_in && addr_in == `BCOC_ADDR_CTRL) begin
         en_q   <= wdata_in[`BCOC_CTRL_EN_BIT];
         stop_q <= wdata_in[`BCOC_CTRL_STOP_BIT];
         str_q  <= wdata_in[`BCOC_CTRL_STR_BIT];
         nstr_q <= wdata_in[`BCOC_CTRL_STRN_LSB +: `BCOC_STRN_W];
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            `BCOC_ADDR_SLOWDIV: rdata_out <= HAS_SLOWDIV ? slowdiv_q : 8'h00;
            `BCOC_ADDR_CTRL:    rdata_out <= {2'h0, nstr_q, 1'b0, str_q, stop_q, en_q};
            `BCOC_ADDR_STATUS:  rdata_out <= {4'h0, mode_q, en_act_q, clk_int};
            default:            rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------
   // Output gating
   // ----------------------------------------
   bcoc_phase_div u_div (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .dv     (dv.gen)
   );

   // Peripheral mode takes the clock from the pin instead
   assign clk_int = (mode_q == bcoc_pkg::BCOC_SPEC_PERIPH) ? pin_s2_q : dv.clk_level;

   // Gate updates only while the clock is low at a half tick, avoiding runt pulses
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         en_act_q <= 1'b0;
      end else if (dv.half_tick && !dv.clk_level) begin
         en_act_q <= en_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bus_clock_pin_out    <= 1'b0;
         bus_clock_pin_oe_out <= 1'b0;
         bus_clock_out        <= 1'b0;
         addr_phase_out       <= 1'b1;
      end else begin
         bus_clock_pin_out    <= en_act_q && dv.clk_level && !stop_q;
         bus_clock_pin_oe_out <= (mode_q != bcoc_pkg::BCOC_SPEC_PERIPH);
         bus_clock_out        <= clk_int;
         addr_phase_out       <= !clk_int;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_low_tick;
      dv.half_tick && !dv.clk_level;
   endsequence

   a_no_drive_periph: assert property (@(posedge clk_in) disable iff (rst_in)
      (mode_q == bcoc_pkg::BCOC_SPEC_PERIPH) |=> !bus_clock_pin_oe_out)
      else $error("pin driven in peripheral mode");
   a_stop_halts: assert property (@(posedge clk_in) disable iff (rst_in)
      stop_q |=> !bus_clock_pin_out)
      else $error("clock runs in stop");
   a_gate_boundary: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(en_act_q) |-> $past(dv.clk_level) == 1'b0)
      else $error("gate changed mid phase");
   a_gate_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      s_low_tick |=> en_act_q == $past(en_q))
      else $error("gate missed enable");
   a_addr_phase: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 addr_phase_out != bus_clock_out)
      else $error("phase marker wrong");
   a_strap_enable: assert property (@(posedge clk_in)
      $fell(rst_in) ##1 mode_q == bcoc_pkg::BCOC_SPEC_SINGLE |-> en_q)
      else $error("special mode not enabled");
   a_div_inert: assert property (@(posedge clk_in) disable iff (rst_in)
      !HAS_SLOWDIV |-> dv.div == 8'h00)
      else $error("divider active on old part");
   a_divreg: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_in && addr_in == `BCOC_ADDR_SLOWDIV && HAS_SLOWDIV) |=> slowdiv_q == $past(wdata_in))
      else $error("divider write lost");
endmodule // bcoc_top

//--- verification/bcoc_ext_model.sv
// External memory side: supplies or follows the bus clock on the shared pin
`timescale 1ns/10ps
module bcoc_ext_model (
   input  wire logic clk_in,
   input  wire logic supply_in,
   input  wire logic pin_out_in,
   input  wire logic pin_oe_in,
   output logic      pin_level_out,
   output int        rise_cnt_out
);
   logic ext_q  = 1'b0;
   logic last_q = 1'b0;
   int   div_q  = 0;
   int   rise_q = 0;
   // Own clock runs only while supplying, so it stands still otherwise
   always @(posedge clk_in) begin
      div_q <= (div_q == 2) ? 0 : div_q + 1;
      if (supply_in && div_q == 2) ext_q <= ~ext_q;
      last_q <= pin_level_out;
      if (pin_level_out && !last_q) rise_q <= rise_q + 1;
   end
   // Undriven pin shows the own clock while supplying, else the inverse of its last level, never a stale copy
   always_comb pin_level_out = pin_oe_in ? pin_out_in : (supply_in ? ext_q : ~last_q);
   assign rise_cnt_out = rise_q;
endmodule // bcoc_ext_model

//--- verification/bcoc_top_test.sv
// Self-checking bench for the bus clock output control block
`timescale 1ns/10ps
`include "bcoc_defines.svh"
module bcoc_top_test;
   logic       clk_in, rst_in, osc_tick_in, wr_in, rd_in, supply, pin_out, pin_oe;
   logic       bc_out, aph_out, pin_lvl, bc_p, pin_p;
   logic [1:0] mode_in;
   logic [7:0] addr_in, wdata_in, rdata_out, rdata_old, v, vo;
   int         miscompares, total_checks, cycles, tog_bc, tog_pin, rise_cnt;
   int         hi_len, short_hi, aph_bad, b, p, s0;
   bcoc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode_in),
      .osc_tick_in(osc_tick_in), .bus_clock_pin_in(pin_lvl), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .bus_clock_pin_out(pin_out), .bus_clock_pin_oe_out(pin_oe),
      .bus_clock_out(bc_out), .addr_phase_out(aph_out));
   // Older silicon without the slow divider shares every input
   bcoc_top #(.HAS_SLOWDIV(1'b0)) old_u (.clk_in(clk_in), .rst_in(rst_in),
      .mode_in(mode_in), .osc_tick_in(osc_tick_in), .bus_clock_pin_in(pin_lvl),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_old), .bus_clock_pin_out(), .bus_clock_pin_oe_out(),
      .bus_clock_out(), .addr_phase_out());
   bcoc_ext_model ext_u (.clk_in(clk_in), .supply_in(supply), .pin_out_in(pin_out),
      .pin_oe_in(pin_oe), .pin_level_out(pin_lvl), .rise_cnt_out(rise_cnt));
   // ----------------------------------------
   // Clock, oscillator and monitors
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // Oscillator edge every second cycle; counters watch both clock outputs
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles % 2 == 0) osc_tick_in <= ~osc_tick_in;
      bc_p <= bc_out;
      pin_p <= pin_out;
      if (bc_out !== bc_p) tog_bc <= tog_bc + 1;
      if (pin_out !== pin_p) tog_pin <= tog_pin + 1;
      if (pin_out === 1'b1) hi_len <= hi_len + 1;
      else begin
         if (pin_p === 1'b1 && hi_len < 2) short_hi <= short_hi + 1;
         hi_len <= 0;
      end
      if (!rst_in && aph_out !== ~bc_out) aph_bad <= aph_bad + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         end_sim();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      v = rdata_out;
      vo = rdata_old;
   endtask
   task automatic win(input int n);
      int b0, p0;
      b0 = tog_bc;
      p0 = tog_pin;
      repeat (n) @(posedge clk_in);
      b = tog_bc - b0;
      p = tog_pin - p0;
   endtask
   task automatic reset_to(input logic [1:0] m);
      mode_in <= m;
      rst_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      check("oe in reset", pin_oe, 1'b0);
      check("phase in reset", aph_out, 1'b1);
      repeat (3) @(posedge clk_in);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rst_in, osc_tick_in, wr_in, rd_in, supply, bc_p, pin_p} = '0;
      {mode_in, addr_in, wdata_in} = '0;
      {cycles, tog_bc, tog_pin, hi_len, short_hi, aph_bad, miscompares, total_checks} = '0;
      reset_to(2'h0);
      rd(`BCOC_ADDR_CTRL);
      check("normal enable", v[0], 1'b0);
      rd(`BCOC_ADDR_STATUS);
      check("status mode", v[3:2], 2'h0);
      rd(`BCOC_ADDR_SLOWDIV);
      check("divider reset", v, `BCOC_SLOWDIV_RST);
      win(80);
      check("normal pin idle", p == 0, 1'b1);
      s0 = short_hi;
      wr(`BCOC_ADDR_CTRL, 8'h01);
      repeat (8) @(posedge clk_in);
      win(80);
      check("pin enabled", p > 0, 1'b1);
      check("rate div0", b >= 18 && b <= 22, 1'b1);
      wr(`BCOC_ADDR_SLOWDIV, 8'h01);
      rd(`BCOC_ADDR_SLOWDIV);
      check("divider rw", v, 8'h01);
      check("old divider", vo, 8'h00);
      win(80);
      check("rate div1", b >= 8 && b <= 12, 1'b1);
      rd(8'h10);
      check("unmapped", v, 8'h00);
      wr(`BCOC_ADDR_SLOWDIV, 8'h00);
      wr(`BCOC_ADDR_CTRL, 8'h15);
      win(80);
      check("stretched", b >= 11 && b <= 16, 1'b1);
      check("no short pulse", short_hi == s0, 1'b1);
      wr(`BCOC_ADDR_CTRL, 8'h03);
      repeat (10) @(posedge clk_in);
      win(80);
      check("stop clock", b == 0, 1'b1);
      check("stop pin", pin_out, 1'b0);
      check("phase tracks", aph_bad == 0 && rise_cnt > 0, 1'b1);
      $display("test normal single done");
      reset_to(2'h1);
      rd(`BCOC_ADDR_CTRL);
      check("special enable", v[0], 1'b1);
      win(80);
      check("special pin on", p > 0, 1'b1);
      s0 = short_hi;
      wr(`BCOC_ADDR_CTRL, 8'h00);
      repeat (10) @(posedge clk_in);
      win(80);
      check("special pin off", p == 0, 1'b1);
      check("no short pulse off", short_hi == s0, 1'b1);
      $display("test special single done");
      supply <= 1'b1;
      reset_to(2'h2);
      win(80);
      check("periph follows", b >= 22 && b <= 30, 1'b1);
      check("periph oe", pin_oe, 1'b0);
      supply <= 1'b0;
      $display("test special peripheral done");
      end_sim();
   end
endmodule // bcoc_top_test
